// file: dmca_top.sv
`timescale 1ns/10ps
`include "dmca_regs.svh"
// Behaviour
// [R01] reset disables hard error reporting
// [R02] error registers survive reset after hard error
// [R03] diagnostic access via csr, 64-bit data register
// [R04] six diagnostic memory operations supported
// [R05] trigger-address write starts a line read; the code issues a single read of the longword chosen by the lw field
// [R06] read data lands in data register
// [R07] software then reads data register, 64 bits
// [R08] software loads data and address before writing
// [R09] one address register feeds every access
// [R10] row, bank, page fields at fixed bits
// [R11] page offset and longword complete address
// [R12] write stores chosen longword, regenerates ecc
// [R13] bank field used directly, no interleave
// [R14] init writes tag, zeros line, increments
// [R15] scrub rewrites line, correcting single errors
// [R16] csr waits until operation has finished
module dmca_top
  import dmca_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic ce,
  input wire logic csr_valid,
  output logic csr_ready,
  input wire dmca_csr_req_s csr_req,
  output logic csr_rvalid,
  output logic [63:0] csr_rdata,
  output logic mem_valid,
  input wire logic mem_ready,
  output dmca_mem_cmd_s mem_cmd,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata,
  input wire logic [7:0] mem_recc,
  input wire logic hard_err_det,
  output logic hard_err_rpt
);
  dmca_state_e state_reg, state_next; // sequencer
  dmca_op_e op_reg, op_next; // operation in flight
  logic [2:0] cnt_reg, cnt_next; // init/scrub step
  logic [63:0] addr_reg, addr_next; // diagnostic address
  logic [63:0] data_reg, data_next; // diagnostic data
  dmca_mem_cmd_s cmd_reg, cmd_next; // command held on the sdram side
  logic hen_reg; // hard error report enable
  logic [2:0] est_reg; // sticky error status
  logic [63:0] eadr_reg; // address of first logged ecc error
  logic take, trig, step_ok, resp_ok, last, is_rd; // decode wires
  dmca_op_e trig_op;
  logic [7:0] gen_ecc; // check byte of the data register
  logic [63:0] fix_data;
  logic chk_sbe, chk_dbe;

  // trigger decode: a write to one of six addresses names an operation
  function automatic dmca_op_e op_of(input logic [3:0] a);
    case (a)
      `DMCA_A_TRD: op_of = DMCA_OP_RD;
      `DMCA_A_TWR: op_of = DMCA_OP_WR;
      `DMCA_A_TRECC: op_of = DMCA_OP_RECC;
      `DMCA_A_TWECC: op_of = DMCA_OP_WECC;
      `DMCA_A_TINIT: op_of = DMCA_OP_INIT;
      `DMCA_A_TSCRUB: op_of = DMCA_OP_SCRUB;
      default: op_of = DMCA_OP_NONE;
    endcase
  endfunction : op_of

  // build the sdram command for one step of an operation
  function automatic dmca_mem_cmd_s mk_cmd(input dmca_op_e op, input logic [2:0] cnt, input logic wr,
                                           input logic [63:0] a, input logic [63:0] d, input logic [7:0] e);
    mk_cmd.row = a[`DMCA_F_ROW]; // [R10]
    mk_cmd.bank = a[`DMCA_F_BANK]; // straight through, no interleave [R13]
    mk_cmd.page = a[`DMCA_F_PAGE]; // [R10]
    mk_cmd.pofs = a[`DMCA_F_POFS]; // [R11]
    mk_cmd.lw = a[`DMCA_F_LW]; // [R11]
    mk_cmd.data = d;
    mk_cmd.ecc = e;
    case (op)
      DMCA_OP_RD, DMCA_OP_RECC: mk_cmd.kind = DMCA_K_RD;
      DMCA_OP_WR: mk_cmd.kind = DMCA_K_WORD; // one longword, fresh ecc [R12]
      DMCA_OP_WECC:
      begin
        mk_cmd.kind = DMCA_K_ECC;
        mk_cmd.ecc = d[7:0];
      end
      DMCA_OP_INIT:
      begin
        // step 0 writes the tag, steps 1..4 zero the longwords; lw taken from the step count [R14]
        mk_cmd.kind = (cnt == 3'h0) ? DMCA_K_TAG : DMCA_K_WORD;
        mk_cmd.lw = 2'(cnt - 3'h1);
        mk_cmd.data = (cnt == 3'h0) ? d : `DMCA_ZERO64;
        mk_cmd.ecc = `DMCA_ZERO_ECC;
      end
      DMCA_OP_SCRUB:
      begin
        mk_cmd.kind = wr ? DMCA_K_WORD : DMCA_K_RD; // [R15]
        mk_cmd.lw = cnt[1:0];
      end
      default: mk_cmd.kind = DMCA_K_RD;
    endcase
  endfunction : mk_cmd

  // ecc for the data register, and check of returning read data
  dmca_ecc u_gen (
    .data(data_reg),
    .ecc_in(`DMCA_ZERO_ECC),
    .ecc_gen(gen_ecc),
    .data_fix(),
    .sbe(),
    .dbe()
  );
  dmca_ecc u_chk (
    .data(mem_rdata),
    .ecc_in(mem_recc),
    .ecc_gen(),
    .data_fix(fix_data),
    .sbe(chk_sbe),
    .dbe(chk_dbe)
  );

  // handshakes; the csr port stalls while an operation runs, so a later
  // read of the data register always sees the finished result
  assign csr_ready = (state_reg == DMCA_S_IDLE); // [R16]
  assign take = ce & csr_valid & csr_ready; // [R03]
  assign trig_op = op_of(csr_req.addr);
  assign trig = take & csr_req.we & (trig_op != DMCA_OP_NONE); // [R04] [R05]
  assign mem_valid = ce & (state_reg == DMCA_S_CMD);
  assign mem_cmd = cmd_reg;
  assign step_ok = mem_valid & mem_ready;
  assign resp_ok = ce & (state_reg == DMCA_S_RESP) & mem_rvalid;
  assign is_rd = (cmd_reg.kind == DMCA_K_RD);
  assign last = (op_reg == DMCA_OP_INIT) ? (cnt_reg == `DMCA_INIT_LAST) :
                (op_reg == DMCA_OP_SCRUB) ? (cnt_reg == `DMCA_SCRUB_LAST) : 1'b1;

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    case (state_reg)
      DMCA_S_IDLE:
      if (trig)
      begin
        state_next = DMCA_S_CMD;
        op_next = trig_op;
        cnt_next = 3'h0;
        cmd_next = mk_cmd(trig_op, 3'h0, 1'b0, addr_reg, data_reg, gen_ecc);
      end
      DMCA_S_CMD:
      if (step_ok)
      begin
        if (is_rd)
          state_next = DMCA_S_RESP;
        else if (!last)
        begin
          // more steps: advance and present the next command at once
          cnt_next = 3'(cnt_reg + 3'h1);
          cmd_next = mk_cmd(op_reg, 3'(cnt_reg + 3'h1), 1'b0, addr_reg, data_reg, gen_ecc);
        end
        else
          state_next = DMCA_S_IDLE;
      end
      DMCA_S_RESP:
      if (resp_ok)
      begin
        if (op_reg == DMCA_OP_SCRUB)
        begin
          // write back corrected data with the stored ecc, which matches it unless the error was in the check byte or in two bits
          state_next = DMCA_S_CMD;
          cmd_next = mk_cmd(op_reg, cnt_reg, 1'b1, addr_reg, fix_data, mem_recc); // [R15]
        end
        else
          state_next = DMCA_S_IDLE;
      end
      default: state_next = DMCA_S_IDLE;
    endcase
  end

  // register next values
  always_comb
  begin
    addr_next = addr_reg;
    data_next = data_reg;
    if (take & csr_req.we & (csr_req.addr == `DMCA_A_ADDR))
      addr_next = csr_req.wdata; // [R09]
    if (take & csr_req.we & (csr_req.addr == `DMCA_A_DATA))
      data_next = csr_req.wdata; // [R03]
    // init moves on to the next sequential line when its last step goes out
    if (step_ok & last & (op_reg == DMCA_OP_INIT))
      addr_next[`DMCA_F_PGOFS] = 21'(addr_reg[`DMCA_F_PGOFS] + `DMCA_PGOFS_ONE); // [R14]
    if (resp_ok & (op_reg == DMCA_OP_RD))
      data_next = fix_data; // [R06]
    if (resp_ok & (op_reg == DMCA_OP_RECC))
      data_next = {`DMCA_ZERO56, mem_recc};
  end

  // sequencer and diagnostic registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= DMCA_S_IDLE;
      op_reg <= DMCA_OP_NONE;
      cnt_reg <= 3'h0;
      cmd_reg <= '0;
      addr_reg <= `DMCA_ZERO64;
      data_reg <= `DMCA_ZERO64;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  // report enable and outgoing hard error; reset always clears enable
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hen_reg <= 1'b0; // [R01]
      hard_err_rpt <= 1'b0;
    end
    else if (ce)
    begin
      if (take & csr_req.we & (csr_req.addr == `DMCA_A_CTRL))
        hen_reg <= csr_req.wdata[`DMCA_CTRL_HREN];
      hard_err_rpt <= hard_err_det & hen_reg;
    end
  end

  // error log: only power-on clears it asynchronously; system reset clears
  // it only when no hard error was held, so the cause survives a reboot
  always_ff @(posedge clk or negedge por_b)
  begin
    if (!por_b)
    begin
      est_reg <= 3'h0;
      eadr_reg <= `DMCA_ZERO64;
    end
    else if (!rst_b)
    begin
      if (!est_reg[`DMCA_ST_HARD])
      begin
        est_reg <= 3'h0; // [R02]
        eadr_reg <= `DMCA_ZERO64;
      end
    end
    else if (ce)
    begin
      // software write clears; a new event in the same cycle wins
      if (take & csr_req.we & (csr_req.addr == `DMCA_A_ERRST))
        est_reg <= 3'h0; // [R02]
      if (resp_ok & chk_sbe)
        est_reg[`DMCA_ST_SBE] <= 1'b1;
      if (resp_ok & chk_dbe)
        est_reg[`DMCA_ST_DBE] <= 1'b1;
      if (hard_err_det)
        est_reg[`DMCA_ST_HARD] <= 1'b1;
      if (resp_ok & (chk_sbe | chk_dbe) & (est_reg[1:0] == 2'h0))
        eadr_reg <= addr_reg;
    end
  end

  // read data and its strobe, one cycle after the request is taken
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      csr_rvalid <= 1'b0;
      csr_rdata <= `DMCA_ZERO64;
    end
    else if (ce)
    begin
      csr_rvalid <= take & ~csr_req.we;
      // load only on a taken read, so the answer holds until the next one
      if (take & ~csr_req.we)
      begin
        case (csr_req.addr)
          `DMCA_A_ADDR: csr_rdata <= addr_reg;
          `DMCA_A_DATA: csr_rdata <= data_reg; // [R07]
          `DMCA_A_CTRL: csr_rdata <= {63'h0, hen_reg};
          `DMCA_A_ERRST: csr_rdata <= {`DMCA_ZERO61, est_reg};
          `DMCA_A_ERRADR: csr_rdata <= eadr_reg;
          default: csr_rdata <= `DMCA_ZERO64; // triggers and holes read zero
        endcase
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_hen_reset_off: assert property ($rose(rst_b) |-> !hen_reg) // [R01]
    else $error("report enable not cleared by reset");
  a_errlog_held: assert property (@(posedge clk) disable iff (!por_b) // [R02]
    (est_reg[`DMCA_ST_HARD] && !rst_b) |=> $stable(eadr_reg) && est_reg[`DMCA_ST_HARD])
    else $error("error log lost across reset");
  a_data_readback: assert property (take && !csr_req.we && csr_req.addr == `DMCA_A_DATA && ce // [R03]
    |=> csr_rvalid && csr_rdata == $past(data_reg))
    else $error("data register readback wrong");
  a_trig_read_cmd: assert property (trig && trig_op == DMCA_OP_RD && ce // [R05]
    |=> state_reg == DMCA_S_CMD && cmd_reg.kind == DMCA_K_RD && cmd_reg.lw == addr_reg[`DMCA_F_LW])
    else $error("read trigger did not issue read");
  a_read_capture: assert property (resp_ok && op_reg == DMCA_OP_RD // [R06]
    |=> data_reg == $past(fix_data) && state_reg == DMCA_S_IDLE)
    else $error("read data not captured");
  a_addr_fields: assert property (mem_valid |-> mem_cmd.row == addr_reg[`DMCA_F_ROW] // [R10]
    && mem_cmd.bank == addr_reg[`DMCA_F_BANK] && mem_cmd.page == addr_reg[`DMCA_F_PAGE])
    else $error("address fields mismatch");
  a_write_word: assert property (mem_valid && op_reg == DMCA_OP_WR |-> mem_cmd.kind == DMCA_K_WORD // [R12]
    && mem_cmd.data == data_reg && mem_cmd.ecc == gen_ecc && mem_cmd.lw == addr_reg[`DMCA_F_LW])
    else $error("write command wrong");
  a_init_incr: assert property (step_ok && last && op_reg == DMCA_OP_INIT // [R14]
    |=> addr_reg[`DMCA_F_PGOFS] == 21'($past(addr_reg[`DMCA_F_PGOFS]) + `DMCA_PGOFS_ONE)
    && addr_reg[4:0] == $past(addr_reg[4:0]))
    else $error("init did not advance line");
  a_scrub_fix: assert property (resp_ok && op_reg == DMCA_OP_SCRUB // [R15]
    |=> cmd_reg.kind == DMCA_K_WORD && cmd_reg.data == $past(fix_data) && cmd_reg.ecc == $past(mem_recc))
    else $error("scrub write-back wrong");
  a_busy_stall: assert property (state_reg != DMCA_S_IDLE |=> !csr_rvalid && $stable(hen_reg)) // [R16]
    else $error("csr taken while busy");

  c_diag_read: cover property (resp_ok && op_reg == DMCA_OP_RD);
  c_init_done: cover property (step_ok && last && op_reg == DMCA_OP_INIT);
  c_scrub_sbe: cover property (resp_ok && op_reg == DMCA_OP_SCRUB && chk_sbe);
  c_ecc_write: cover property (step_ok && op_reg == DMCA_OP_WECC);
endmodule : dmca_top

// file: dmca_regs.svh
`ifndef DMCA_REGS_SVH
`define DMCA_REGS_SVH

// csr word indices
`define DMCA_A_ADDR 4'h0
`define DMCA_A_DATA 4'h1
`define DMCA_A_TRD 4'h2
`define DMCA_A_TWR 4'h3
`define DMCA_A_TRECC 4'h4
`define DMCA_A_TWECC 4'h5
`define DMCA_A_TINIT 4'h6
`define DMCA_A_TSCRUB 4'h7
`define DMCA_A_CTRL 4'h8
`define DMCA_A_ERRST 4'h9
`define DMCA_A_ERRADR 4'hA

// address register fields (bit 0 = msb numbering mapped to lsb-0)
`define DMCA_F_ROW 33:31
`define DMCA_F_BANK 27:26
`define DMCA_F_PAGE 25:12
`define DMCA_F_POFS 11:5
`define DMCA_F_LW 4:3
`define DMCA_F_PGOFS 25:5
`define DMCA_PGOFS_ONE 21'h000001

// control and status bits
`define DMCA_CTRL_HREN 0
`define DMCA_ST_SBE 0
`define DMCA_ST_DBE 1
`define DMCA_ST_HARD 2

// counts and reset values
`define DMCA_INIT_LAST 3'h4
`define DMCA_SCRUB_LAST 3'h3
`define DMCA_ZERO64 64'h0000000000000000
`define DMCA_ZERO_ECC 8'h00
`define DMCA_ZERO56 56'h00000000000000
`define DMCA_ZERO61 61'h0000000000000000

`endif

// file: dmca_pkg.sv
package dmca_pkg;

  // diagnostic operations
  typedef enum logic [2:0] {
    DMCA_OP_RD = 3'h0,
    DMCA_OP_WR = 3'h1,
    DMCA_OP_RECC = 3'h2,
    DMCA_OP_WECC = 3'h3,
    DMCA_OP_INIT = 3'h4,
    DMCA_OP_SCRUB = 3'h5,
    DMCA_OP_NONE = 3'h7
  } dmca_op_e;

  // sdram-side command kinds
  typedef enum logic [1:0] {
    DMCA_K_RD = 2'h0,
    DMCA_K_WORD = 2'h1,
    DMCA_K_ECC = 2'h2,
    DMCA_K_TAG = 2'h3
  } dmca_kind_e;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    DMCA_S_IDLE = 3'h1,
    DMCA_S_CMD = 3'h2,
    DMCA_S_RESP = 3'h4
  } dmca_state_e;

  typedef struct packed {
    dmca_kind_e kind;
    logic [2:0] row;
    logic [1:0] bank;
    logic [13:0] page;
    logic [6:0] pofs;
    logic [1:0] lw;
    logic [63:0] data;
    logic [7:0] ecc;
  } dmca_mem_cmd_s;

  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [63:0] wdata;
  } dmca_csr_req_s;

endpackage : dmca_pkg

// file: dmca_ecc.sv
`timescale 1ns/10ps
// single-error-correct code over one 64-bit word: low 7 check bits are the
// xor of (index+1) of every set bit, bit 7 is data parity
module dmca_ecc
  import dmca_pkg::*;
(
  input wire logic [63:0] data,
  input wire logic [7:0] ecc_in,
  output logic [7:0] ecc_gen,
  output logic [63:0] data_fix,
  output logic sbe,
  output logic dbe
);
  logic [7:0] acc [0:64]; // running xor chain
  logic [7:0] syn; // syndrome
  logic [63:0] flip; // one-hot correction mask

  assign acc[0] = `DMCA_ZERO_ECC;
  genvar i;
  generate
    for (i = 0; i < 64; i++)
    begin : g_bit
      // each set bit contributes its position code and a parity bit
      assign acc[i+1] = acc[i] ^ (data[i] ? {1'b1, 7'(i + 1)} : `DMCA_ZERO_ECC);
      // flip only on parity mismatch with a matching position
      assign flip[i] = syn[7] & (syn[6:0] == 7'(i + 1));
    end
  endgenerate

  assign ecc_gen = acc[64];
  assign syn = ecc_gen ^ ecc_in;
  assign data_fix = data ^ flip;
  // a parity miss means one bit (data or check) went bad
  assign sbe = syn[7];
  // a position mismatch with good parity cannot be corrected
  assign dbe = ~syn[7] & (|syn[6:0]);
endmodule : dmca_ecc

// file: dmca_mem_model.sv
`timescale 1ns/10ps
// sdram array behind the diagnostic port; slow adds stalls and read latency
module dmca_mem_model
  import dmca_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire dmca_mem_cmd_s mem_cmd,
  output logic mem_rvalid,
  output logic [63:0] mem_rdata,
  output logic [7:0] mem_recc
);
  logic [63:0] md [logic [27:0]]; // words by line address and lw
  logic [7:0] me [logic [27:0]]; // stored check bytes
  logic [63:0] mt [logic [25:0]]; // tag per line
  logic [27:0] key_reg; // address of the outstanding read
  logic [2:0] wait_reg; // read latency still to run
  logic pend_reg; // a read is outstanding
  // bank is taken as sent, no interleave on this side
  wire [27:0] key = {mem_cmd.row, mem_cmd.bank, mem_cmd.page, mem_cmd.pofs, mem_cmd.lw};
  wire take = mem_valid & mem_ready;
  initial
  begin
    mem_ready = 1'b1;
    mem_rvalid = 1'b0;
    mem_rdata = 64'h0;
    mem_recc = 8'h00;
    pend_reg = 1'b0;
  end
  // accept commands and return read data
  always @(posedge clk)
  begin
    mem_ready <= slow ? ~mem_ready : 1'b1;
    mem_rvalid <= 1'b0;
    // released bus inverts every cycle, so the last word shows again on alternate cycles
    mem_rdata <= ~mem_rdata;
    mem_recc <= ~mem_recc;
    if (pend_reg && wait_reg == 3'h0)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata <= md[key_reg];
      mem_recc <= me[key_reg];
      pend_reg <= 1'b0;
    end
    else if (pend_reg)
      wait_reg <= wait_reg - 3'h1;
    if (take)
    begin
      case (mem_cmd.kind)
        DMCA_K_RD:
        begin
          pend_reg <= 1'b1;
          key_reg <= key;
          wait_reg <= slow ? 3'h3 : 3'h0;
        end
        DMCA_K_WORD:
        begin
          md[key] = mem_cmd.data;
          me[key] = mem_cmd.ecc;
        end
        DMCA_K_ECC: me[key] = mem_cmd.ecc;
        default: mt[key[27:2]] = mem_cmd.data;
      endcase
    end
  end
endmodule : dmca_mem_model

// file: test_diag_memory_csr_access.sv
`timescale 1ns/10ps
`include "dmca_regs.svh"
// csr-side bench for the diagnostic block against the sdram model
module test_diag_memory_csr_access
  import dmca_pkg::*;
();
  logic clk, rst_b, por_b, ce, csr_valid, csr_ready, csr_rvalid, slow;
  logic mem_valid, mem_ready, mem_rvalid, hard_err_det, hard_err_rpt;
  dmca_csr_req_s csr_req;
  dmca_mem_cmd_s mem_cmd;
  logic [63:0] csr_rdata, mem_rdata;
  logic [7:0] mem_recc;
  int bad_count, n_checks;
  dmca_top u_dut (.clk(clk), .rst_b(rst_b), .por_b(por_b), .ce(ce), .csr_valid(csr_valid),
    .csr_ready(csr_ready), .csr_req(csr_req), .csr_rvalid(csr_rvalid), .csr_rdata(csr_rdata),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_cmd(mem_cmd), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .mem_recc(mem_recc), .hard_err_det(hard_err_det),
    .hard_err_rpt(hard_err_rpt));
  dmca_mem_model u_mem (.clk(clk), .slow(slow), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_cmd(mem_cmd), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_recc(mem_recc));
  // field packer, bits as the address register holds them
  function automatic logic [63:0] mk(logic [2:0] r, logic [1:0] b, logic [13:0] p, logic [6:0] o,
    logic [1:0] l);
    logic [63:0] a;
    a = 64'h0;
    a[`DMCA_F_ROW] = r;
    a[`DMCA_F_BANK] = b;
    a[`DMCA_F_PAGE] = p;
    a[`DMCA_F_POFS] = o;
    a[`DMCA_F_LW] = l;
    return a;
  endfunction : mk
  function automatic logic [27:0] fk(logic [63:0] a, logic [1:0] l);
    return {a[`DMCA_F_ROW], a[`DMCA_F_BANK], a[`DMCA_F_PGOFS], l};
  endfunction : fk
  // check byte: xor of (index+1) of set bits, plus parity on top
  function automatic logic [7:0] fe(logic [63:0] d);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 64; i++)
      if (d[i])
        e = {~e[7], e[6:0] ^ 7'(i + 1)};
    return e;
  endfunction : fe
  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk64
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // one csr transfer, held until the block takes it
  task automatic csr_op(input logic we, input logic [3:0] idx, input logic [63:0] wd,
    input logic [63:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    csr_valid <= 1'b1;
    csr_req <= {we, idx, wd};
    @(negedge clk);
    while (csr_ready !== 1'b1)
    begin
      n++;
      if (n > 300)
      begin
        bad_count++;
        $display("ERROR %0t csr wait ran out", $time);
        test_done;
      end
      @(negedge clk);
    end
    @(posedge clk);
    csr_valid <= 1'b0;
    @(negedge clk);
    if (!we)
    begin
      chk64({63'h0, csr_rvalid}, 64'h1);
      chk64(csr_rdata, exp);
    end
  endtask : csr_op
  task automatic wr(input logic [3:0] idx, input logic [63:0] d);
    csr_op(1'b1, idx, d, 64'h0);
  endtask : wr
  task automatic rdc(input logic [3:0] idx, input logic [63:0] exp);
    csr_op(1'b0, idx, 64'h0, exp);
  endtask : rdc
  // pulse a hard error and look at the report one cycle on
  task automatic hard_pulse(input logic exp);
    @(posedge clk);
    hard_err_det <= 1'b1;
    @(posedge clk);
    hard_err_det <= 1'b0;
    @(negedge clk);
    chk64({63'h0, hard_err_rpt}, {63'h0, exp});
  endtask : hard_pulse
  task automatic t_reset;
    rdc(`DMCA_A_ADDR, 64'h0);
    rdc(`DMCA_A_DATA, 64'h0);
    rdc(`DMCA_A_CTRL, 64'h0);
    hard_pulse(1'b0);
    rdc(4'hB, 64'h0);
    rdc(`DMCA_A_TRD, 64'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_write_read;
    logic [63:0] a, a2, d;
    a = mk(3'h5, 2'h2, 14'h1A5, 7'h33, 2'h2);
    a2 = mk(3'h5, 2'h1, 14'h1A5, 7'h33, 2'h2);
    d = 64'h0123456789ABCDEF;
    wr(`DMCA_A_ADDR, a);
    wr(`DMCA_A_DATA, d);
    wr(`DMCA_A_TWR, 64'h0);
    rdc(`DMCA_A_ADDR, a);
    rdc(`DMCA_A_DATA, d);
    chk64(u_mem.md[fk(a, 2'h2)], d);
    chk64({56'h0, u_mem.me[fk(a, 2'h2)]}, {56'h0, fe(d)});
    wr(`DMCA_A_ADDR, a2);
    wr(`DMCA_A_DATA, ~d);
    wr(`DMCA_A_TWR, 64'h0);
    rdc(`DMCA_A_ADDR, a2);
    chk64(u_mem.md[fk(a2, 2'h2)], ~d);
    chk64(u_mem.md[fk(a, 2'h2)], d);
    @(posedge clk);
    slow <= 1'b1;
    wr(`DMCA_A_ADDR, a);
    wr(`DMCA_A_TRD, 64'h0);
    rdc(`DMCA_A_DATA, d);
    $display("test write read done");
  endtask : t_write_read
  task automatic t_ecc;
    wr(`DMCA_A_DATA, 64'hFFFFFFFFFFFFFF5A);
    wr(`DMCA_A_TWECC, 64'h0);
    rdc(`DMCA_A_DATA, 64'hFFFFFFFFFFFFFF5A);
    chk64({56'h0, u_mem.me[fk(mk(3'h5, 2'h2, 14'h1A5, 7'h33, 2'h0), 2'h2)]}, 64'h5A);
    wr(`DMCA_A_TRECC, 64'h0);
    rdc(`DMCA_A_DATA, 64'h5A);
    $display("test ecc done");
  endtask : t_ecc
  task automatic t_init;
    logic [63:0] a, t;
    a = mk(3'h3, 2'h1, 14'h0FF, 7'h7F, 2'h1);
    t = 64'hA5A5C3C35A5A3C3C;
    wr(`DMCA_A_ADDR, a);
    wr(`DMCA_A_DATA, t);
    wr(`DMCA_A_TINIT, 64'h0);
    rdc(`DMCA_A_ADDR, mk(3'h3, 2'h1, 14'h100, 7'h00, 2'h1));
    rdc(`DMCA_A_DATA, t);
    for (int i = 0; i < 4; i++)
      chk64(u_mem.md[fk(a, 2'(i))], 64'h0);
    chk64(u_mem.mt[26'(fk(a, 2'h0) >> 2)], t);
    $display("test init done");
  endtask : t_init
  // one flipped bit in the second longword must come back corrected
  task automatic t_scrub;
    logic [63:0] a, d;
    a = mk(3'h1, 2'h3, 14'h2AA, 7'h10, 2'h0);
    d = 64'hFEDCBA9876543210;
    for (int i = 0; i < 4; i++)
    begin
      u_mem.md[fk(a, 2'(i))] = d + 64'(i);
      u_mem.me[fk(a, 2'(i))] = fe(d + 64'(i));
    end
    u_mem.md[fk(a, 2'h1)] = (d + 64'h1) ^ 64'h0000000000000200;
    // earlier hard pulse and bad check byte left status bits set
    wr(`DMCA_A_ERRST, 64'h0);
    wr(`DMCA_A_ADDR, a);
    wr(`DMCA_A_TSCRUB, 64'h0);
    rdc(`DMCA_A_ADDR, a);
    for (int i = 0; i < 4; i++)
      chk64(u_mem.md[fk(a, 2'(i))], d + 64'(i));
    rdc(`DMCA_A_ERRST, 64'h1);
    rdc(`DMCA_A_ERRADR, a);
    $display("test scrub done");
  endtask : t_scrub
  // a logged hard error keeps the log through a system reset
  task automatic t_errlog;
    wr(`DMCA_A_CTRL, 64'h1);
    hard_pulse(1'b1);
    rdc(`DMCA_A_ERRST, 64'h5);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdc(`DMCA_A_ERRST, 64'h5);
    rdc(`DMCA_A_CTRL, 64'h0);
    hard_pulse(1'b0);
    wr(`DMCA_A_ERRST, 64'h0);
    rdc(`DMCA_A_ERRST, 64'h0);
    $display("test error log done");
  endtask : t_errlog
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // reset, then the scenarios in turn
  initial
  begin
    rst_b = 1'b0;
    por_b = 1'b0;
    ce = 1'b1;
    slow = 1'b0;
    csr_valid = 1'b0;
    csr_req = '0;
    hard_err_det = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    t_reset;
    t_write_read;
    t_ecc;
    t_init;
    t_scrub;
    t_errlog;
    test_done;
  end
endmodule : test_diag_memory_csr_access
